/* common/embpc_pkg.sv */
// Package: register map, field positions and carrier structs for the memory bus pin control
package embpc_pkg;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_P14_DATA = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_P14_DIR = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ALT_SEL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int MODE_W = 4;
	localparam int BIT_BUS_CLOCK = 0;
	localparam int BIT_BYTE_LANE2 = 1;
	localparam int BIT_BYTE_LANE3 = 2;
	localparam int BIT_UPPER_DATA = 3;
	localparam int P14_W = 3;
	localparam int ALT_N = 8;
	localparam int HALF_W = 16;
	localparam int ADDR_BUS_W = 24;
	localparam int CS_N = 4;
	localparam int STAT_WIDTH32 = 0;
	localparam int STAT_WAIT = 1;
	localparam int SYNC_W = 2 * HALF_W + P14_W + 1 + 2 * ALT_N;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	// From the internal bus controller
	typedef struct packed {
		logic [ADDR_BUS_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic doe;
		logic wr_strobe;
		logic rd_strobe;
		logic [CS_N-1:0] chip_select;
		logic [3:0] byte_lane_strobe;
		logic bus_clock;
	} embpc_ctrl_s;

	// Dedicated output pins that need no mode control
	typedef struct packed {
		logic [ADDR_BUS_W-1:0] addr;
		logic [HALF_W-1:0] lo_out;
		logic lo_oe;
		logic wr_strobe;
		logic rd_strobe;
		logic [CS_N-1:0] chip_select;
		logic [1:0] byte_lane_strobe;
	} embpc_mem_pins_s;

	typedef struct packed {
		logic [MODE_W-1:0] mode;
		logic [P14_W-1:0] p14_dat;
		logic [P14_W-1:0] p14_dir;
		logic [ALT_N-1:0] alt_sel;
		logic [DATA_W-1:0] rdata;
		logic [HALF_W-1:0] up_out;
		logic [HALF_W-1:0] up_oe;
		logic [P14_W-1:0] p14_out;
		logic [P14_W-1:0] p14_oe;
		logic [ALT_N-1:0] alt_in;
		logic [DATA_W-1:0] din;
		embpc_mem_pins_s mem;
	} embpc_state_s;

	localparam embpc_state_s STATE_RST = '0;

endpackage : embpc_pkg

/* hw/embpc_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module embpc_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} embpc_sync_s;

	embpc_sync_s s;
	embpc_sync_s next_s;

	// Meta stage feeds only the second stage
	always_comb begin
		next_s.meta = d;
		next_s.q = s.meta;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;

endmodule : embpc_sync

/* hw/embpc_top.sv */
// External memory bus pin control: width select, shared pin muxing, register port
`timescale 1ns/10ps

// Summary of operation
// - Data bus width 16 or 32, software chosen
// - Upper select drives D31..16 onto shared pins
// - Same bit switches interface 16/32 bit
// - Group 14 unused pins stay 3-bit port
// - Bus clock select puts clock on bit0
// - Lane2 select puts strobe 2 on bit1
// - Lane3 select puts strobe 3 on bit2
// - Address, low data, strobes (byte lanes 0/1 only) on dedicated pins
// - Software picks pin for dual alternative inputs
module embpc_top (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [embpc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [embpc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [embpc_pkg::DATA_W-1:0] reg_rdata,
	input wire embpc_pkg::embpc_ctrl_s ctrl,
	output logic [embpc_pkg::DATA_W-1:0] bus_din,
	output logic bus_wait_req,
	output logic bus_width_32,
	input wire logic [embpc_pkg::HALF_W-1:0] port_up_out,
	input wire logic [embpc_pkg::HALF_W-1:0] port_up_oe,
	output logic [embpc_pkg::HALF_W-1:0] port_up_in,
	input wire logic [embpc_pkg::HALF_W-1:0] up_pin_in,
	output logic [embpc_pkg::HALF_W-1:0] up_pin_out,
	output logic [embpc_pkg::HALF_W-1:0] up_pin_oe,
	input wire logic [embpc_pkg::HALF_W-1:0] lo_pin_in,
	output embpc_pkg::embpc_mem_pins_s mem_pins,
	input wire logic wait_pin,
	input wire logic [embpc_pkg::P14_W-1:0] p14_pin_in,
	output logic [embpc_pkg::P14_W-1:0] p14_pin_out,
	output logic [embpc_pkg::P14_W-1:0] p14_pin_oe,
	input wire logic [embpc_pkg::ALT_N-1:0] alt_pin_a,
	input wire logic [embpc_pkg::ALT_N-1:0] alt_pin_b,
	output logic [embpc_pkg::ALT_N-1:0] alt_in
);

	// ----------------------------------------
	// Pin input synchronisation
	// ----------------------------------------
	logic [embpc_pkg::SYNC_W-1:0] sync_q;
	logic [embpc_pkg::HALF_W-1:0] up_sync;
	logic [embpc_pkg::HALF_W-1:0] lo_sync;
	logic [embpc_pkg::P14_W-1:0] p14_sync;
	logic wait_sync;
	logic [embpc_pkg::ALT_N-1:0] alt_a_sync;
	logic [embpc_pkg::ALT_N-1:0] alt_b_sync;

	embpc_sync #(
		.W(embpc_pkg::SYNC_W)
	) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.d({up_pin_in, lo_pin_in, p14_pin_in, wait_pin, alt_pin_a, alt_pin_b}),
		.q(sync_q)
	);

	assign {up_sync, lo_sync, p14_sync, wait_sync, alt_a_sync, alt_b_sync} = sync_q;

	// ----------------------------------------
	// State
	// ----------------------------------------
	embpc_pkg::embpc_state_s s;
	embpc_pkg::embpc_state_s next_s;
	logic upper_data_bus_select;
	logic bus_clock_pin_select;
	logic byte_lane2_pin_select;
	logic byte_lane3_pin_select;

	assign upper_data_bus_select = s.mode[embpc_pkg::BIT_UPPER_DATA];
	assign bus_clock_pin_select = s.mode[embpc_pkg::BIT_BUS_CLOCK];
	assign byte_lane2_pin_select = s.mode[embpc_pkg::BIT_BYTE_LANE2];
	assign byte_lane3_pin_select = s.mode[embpc_pkg::BIT_BYTE_LANE3];

	always_comb begin
		next_s = s;
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				embpc_pkg::OFS_MODE: next_s.mode = reg_wdata[embpc_pkg::MODE_W-1:0];
				embpc_pkg::OFS_P14_DATA: next_s.p14_dat = reg_wdata[embpc_pkg::P14_W-1:0];
				embpc_pkg::OFS_P14_DIR: next_s.p14_dir = reg_wdata[embpc_pkg::P14_W-1:0];
				embpc_pkg::OFS_ALT_SEL: next_s.alt_sel = reg_wdata[embpc_pkg::ALT_N-1:0];
				default: ;
			endcase
		end
		// Read data stands for exactly one cycle; unmapped reads return zero
		next_s.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				embpc_pkg::OFS_MODE: next_s.rdata[embpc_pkg::MODE_W-1:0] = s.mode;
				embpc_pkg::OFS_P14_DATA: next_s.rdata[embpc_pkg::P14_W-1:0] = p14_sync;
				embpc_pkg::OFS_P14_DIR: next_s.rdata[embpc_pkg::P14_W-1:0] = s.p14_dir;
				embpc_pkg::OFS_ALT_SEL: next_s.rdata[embpc_pkg::ALT_N-1:0] = s.alt_sel;
				embpc_pkg::OFS_STATUS: begin
					next_s.rdata[embpc_pkg::STAT_WIDTH32] = upper_data_bus_select;
					next_s.rdata[embpc_pkg::STAT_WAIT] = wait_sync;
				end
				default: ;
			endcase
		end
		// Upper data pins: bus data or port logic
		if (upper_data_bus_select) begin
			next_s.up_out = ctrl.dout[embpc_pkg::DATA_W-1:embpc_pkg::HALF_W];
			next_s.up_oe = {embpc_pkg::HALF_W{ctrl.doe}};
		end else begin
			next_s.up_out = port_up_out;
			next_s.up_oe = port_up_oe;
		end
		// In 16-bit mode the upper half of read data is forced to zero
		next_s.din = {upper_data_bus_select ? up_sync : {embpc_pkg::HALF_W{1'b0}}, lo_sync};
		// Group 14: each pin independently bus or port
		next_s.p14_out = s.p14_dat;
		next_s.p14_oe = s.p14_dir;
		if (bus_clock_pin_select) begin
			next_s.p14_out[0] = ctrl.bus_clock;
			next_s.p14_oe[0] = 1'b1;
		end
		if (byte_lane2_pin_select) begin
			next_s.p14_out[1] = ctrl.byte_lane_strobe[2];
			next_s.p14_oe[1] = 1'b1;
		end
		if (byte_lane3_pin_select) begin
			next_s.p14_out[2] = ctrl.byte_lane_strobe[3];
			next_s.p14_oe[2] = 1'b1;
		end
		// Dedicated pins follow the controller with no mode control
		next_s.mem.addr = ctrl.addr;
		next_s.mem.lo_out = ctrl.dout[embpc_pkg::HALF_W-1:0];
		next_s.mem.lo_oe = ctrl.doe;
		next_s.mem.wr_strobe = ctrl.wr_strobe;
		next_s.mem.rd_strobe = ctrl.rd_strobe;
		next_s.mem.chip_select = ctrl.chip_select;
		next_s.mem.byte_lane_strobe = ctrl.byte_lane_strobe[1:0];
		// Alternative input from pin b when its select bit is set
		next_s.alt_in = (alt_b_sync & s.alt_sel) | (alt_a_sync & ~s.alt_sel);
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s <= embpc_pkg::STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = s.rdata;
	assign bus_din = s.din;
	assign bus_wait_req = wait_sync;
	assign bus_width_32 = upper_data_bus_select;
	assign port_up_in = up_sync;
	assign up_pin_out = s.up_out;
	assign up_pin_oe = s.up_oe;
	assign mem_pins = s.mem;
	assign p14_pin_out = s.p14_out;
	assign p14_pin_oe = s.p14_oe;
	assign alt_in = s.alt_in;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_mode_write;
		reg_wr && reg_addr == embpc_pkg::OFS_MODE;
	endsequence

	sequence s_mode_read;
		reg_rd && reg_addr == embpc_pkg::OFS_MODE;
	endsequence

	property p_width_select;
		s_mode_write ##1 1'b1 |-> bus_width_32 == $past(reg_wdata[embpc_pkg::BIT_UPPER_DATA]);
	endproperty
	a_width_select: assert property (p_width_select) else $error("width does not follow mode write");

	property p_mode_readback;
		s_mode_write ##1 (s_mode_read and !reg_wr) |=>
			reg_rdata[embpc_pkg::MODE_W-1:0] == $past(reg_wdata[embpc_pkg::MODE_W-1:0], 2);
	endproperty
	a_mode_readback: assert property (p_mode_readback) else $error("mode readback wrong");

	property p_upper_pins;
		1'b1 |=> up_pin_oe == ($past(upper_data_bus_select) ? {embpc_pkg::HALF_W{$past(ctrl.doe)}} : $past(port_up_oe))
			&& up_pin_out == ($past(upper_data_bus_select)
				? $past(ctrl.dout[embpc_pkg::DATA_W-1:embpc_pkg::HALF_W]) : $past(port_up_out));
	endproperty
	a_upper_pins: assert property (p_upper_pins) else $error("upper data pin mux wrong");

	property p_din_upper_zero;
		!upper_data_bus_select |=> bus_din[embpc_pkg::DATA_W-1:embpc_pkg::HALF_W] == '0;
	endproperty
	a_din_upper_zero: assert property (p_din_upper_zero) else $error("upper read data not zero in 16-bit mode");

	property p_p14_port;
		!bus_clock_pin_select |=> p14_pin_out[0] == $past(s.p14_dat[0]) && p14_pin_oe[0] == $past(s.p14_dir[0]);
	endproperty
	a_p14_port: assert property (p_p14_port) else $error("port 14 bit 0 not a port");

	property p_bus_clock_pin;
		bus_clock_pin_select |=> p14_pin_oe[0] && p14_pin_out[0] == $past(ctrl.bus_clock);
	endproperty
	a_bus_clock_pin: assert property (p_bus_clock_pin) else $error("bus clock not on port 14 bit 0");

	property p_lane2_pin;
		byte_lane2_pin_select |=> p14_pin_oe[1] && p14_pin_out[1] == $past(ctrl.byte_lane_strobe[2]);
	endproperty
	a_lane2_pin: assert property (p_lane2_pin) else $error("lane 2 strobe not on port 14 bit 1");

	property p_lane3_pin;
		byte_lane3_pin_select |=> p14_pin_oe[2] && p14_pin_out[2] == $past(ctrl.byte_lane_strobe[3]);
	endproperty
	a_lane3_pin: assert property (p_lane3_pin) else $error("lane 3 strobe not on port 14 bit 2");

	property p_dedicated;
		1'b1 |=> mem_pins.addr == $past(ctrl.addr) && mem_pins.wr_strobe == $past(ctrl.wr_strobe)
			&& mem_pins.chip_select == $past(ctrl.chip_select);
	endproperty
	a_dedicated: assert property (p_dedicated) else $error("dedicated pins do not follow controller");

	property p_wait;
		1'b1 |-> ##2 bus_wait_req == $past(wait_pin, 2);
	endproperty
	a_wait: assert property (p_wait) else $error("wait request not two cycles after pin");

	property p_alt_select;
		1'b1 |=> alt_in == (($past(alt_b_sync) & $past(s.alt_sel)) | ($past(alt_a_sync) & ~$past(s.alt_sel)));
	endproperty
	a_alt_select: assert property (p_alt_select) else $error("alternative input pin choice wrong");

	property p_reset_mode;
		disable iff (1'b0) !rstn |=> s.mode == '0 && !bus_width_32 && p14_pin_oe == '0;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("mode bits not cleared by reset");

endmodule : embpc_top

/* tb/embpc_mem_model.sv */
// Behavioural external memory on the parallel bus
`timescale 1ns/10ps
module embpc_mem_model #(
	parameter logic [31:0] WORD = 32'h5A3C96E1
) (
	input wire logic mclk,
	input wire embpc_pkg::embpc_mem_pins_s mem_pins,
	input wire logic stall,
	output logic [31:0] mem_d,
	output logic wait_pin
);
	initial mem_d = 32'h00000000;
	initial wait_pin = 1'b0;
	// Released bus toggles every cycle so stale data can never pass as a match
	always @(posedge mclk) begin
		mem_d <= mem_pins.rd_strobe ? WORD : ~mem_d;
		wait_pin <= stall;
	end
endmodule : embpc_mem_model

/* tb/test_embpc_top.sv */
// Self-checking bench for the memory bus pin control
`timescale 1ns/10ps
module test_embpc_top;
	localparam logic [31:0] WORD = 32'h5A3C96E1;
	logic mclk, rstn, reg_wr, reg_rd, bus_wait_req, bus_width_32, wait_pin, stall;
	logic [7:0] reg_addr, alt_pin_a, alt_pin_b, alt_in;
	logic [31:0] reg_wdata, reg_rdata, bus_din, mem_d, rd;
	logic [15:0] port_up_out, port_up_oe, up_pin_out, up_pin_oe, port_up_in;
	logic [2:0] p14_pin_out, p14_pin_oe;
	embpc_pkg::embpc_ctrl_s ctrl;
	embpc_pkg::embpc_mem_pins_s mem_pins;
	int num_errors, checks, cycles;
	// ----------------------------------------
	// Wire resolution
	// ----------------------------------------
	wire [15:0] up_pin_in = (up_pin_oe & up_pin_out) | (~up_pin_oe & mem_d[31:16]);
	wire [15:0] lo_pin_in = mem_pins.lo_oe ? mem_pins.lo_out : mem_d[15:0];
	wire [2:0] p14_pin_in = p14_pin_oe & p14_pin_out;

	embpc_top DUT (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl(ctrl), .bus_din(bus_din), .bus_wait_req(bus_wait_req),
		.bus_width_32(bus_width_32), .port_up_out(port_up_out), .port_up_oe(port_up_oe), .port_up_in(port_up_in),
		.up_pin_in(up_pin_in), .up_pin_out(up_pin_out), .up_pin_oe(up_pin_oe), .lo_pin_in(lo_pin_in),
		.mem_pins(mem_pins), .wait_pin(wait_pin), .p14_pin_in(p14_pin_in), .p14_pin_out(p14_pin_out),
		.p14_pin_oe(p14_pin_oe), .alt_pin_a(alt_pin_a), .alt_pin_b(alt_pin_b), .alt_in(alt_in));
	embpc_mem_model #(.WORD(WORD)) mem (.mclk(mclk), .mem_pins(mem_pins), .stall(stall), .mem_d(mem_d),
		.wait_pin(wait_pin));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		rd = reg_rdata;
	endtask : rdr
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdr(embpc_pkg::OFS_MODE);
		chk("mode", 32'h0, rd);
		chk("width", 32'h0, {31'h0, bus_width_32});
		chk("up_oe", 32'h0, {16'h0, up_pin_oe});
		$display("test reset done");
	endtask : t_reset
	task automatic t_width();
		@(posedge mclk);
		ctrl.doe <= 1'b1;
		ctrl.dout <= 32'h1234ABCD;
		port_up_out <= 16'h0F0F;
		port_up_oe <= 16'h00FF;
		wr(embpc_pkg::OFS_MODE, 32'h8);
		chk("width", 32'h1, {31'h0, bus_width_32});
		tick(1);
		chk("up_out", 32'h1234, {16'h0, up_pin_out});
		chk("up_oe", 32'hFFFF, {16'h0, up_pin_oe});
		chk("lo_out", 32'hABCD, {16'h0, mem_pins.lo_out});
		rdr(embpc_pkg::OFS_STATUS);
		chk("status", 32'h1, rd & 32'h1);
		chk("port_up_in", 32'h1234, {16'h0, port_up_in});
		wr(embpc_pkg::OFS_MODE, 32'h0);
		tick(1);
		chk("up_out", 32'h0F0F, {16'h0, up_pin_out});
		chk("up_oe", 32'h00FF, {16'h0, up_pin_oe});
		chk("width", 32'h0, {31'h0, bus_width_32});
		$display("test width done");
	endtask : t_width
	task automatic t_p14();
		@(posedge mclk);
		ctrl.bus_clock <= 1'b1;
		ctrl.byte_lane_strobe <= 4'hC;
		wr(embpc_pkg::OFS_P14_DIR, 32'h7);
		wr(embpc_pkg::OFS_P14_DATA, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wr(embpc_pkg::OFS_MODE, 32'h1 << i);
			tick(1);
			chk("p14_out", 32'h1 << i, {29'h0, p14_pin_out});
			chk("p14_oe", 32'h7, {29'h0, p14_pin_oe});
		end
		wr(embpc_pkg::OFS_MODE, 32'h0);
		wr(embpc_pkg::OFS_P14_DATA, 32'h5);
		tick(1);
		chk("p14_out", 32'h5, {29'h0, p14_pin_out});
		// Pin level needs two synchroniser stages before the read samples it
		tick(2);
		rdr(embpc_pkg::OFS_P14_DATA);
		chk("p14_in", 32'h5, rd);
		$display("test group14 done");
	endtask : t_p14
	task automatic t_dedicated();
		@(posedge mclk);
		ctrl.addr <= 24'hC3A55A;
		ctrl.wr_strobe <= 1'b1;
		ctrl.chip_select <= 4'hA;
		ctrl.byte_lane_strobe <= 4'hD;
		tick(1);
		chk("addr", 32'hC3A55A, {8'h0, mem_pins.addr});
		chk("cs", 32'hA, {28'h0, mem_pins.chip_select});
		chk("lanes", 32'h1, {30'h0, mem_pins.byte_lane_strobe});
		chk("wr_strobe", 32'h1, {31'h0, mem_pins.wr_strobe});
		$display("test dedicated done");
	endtask : t_dedicated
	task automatic t_read();
		@(posedge mclk);
		ctrl.doe <= 1'b0;
		ctrl.rd_strobe <= 1'b1;
		wr(embpc_pkg::OFS_MODE, 32'h8);
		tick(6);
		chk("din32", WORD, bus_din);
		wr(embpc_pkg::OFS_MODE, 32'h0);
		tick(6);
		chk("din16", {16'h0, WORD[15:0]}, bus_din);
		ctrl.rd_strobe <= 1'b0;
		$display("test read done");
	endtask : t_read
	task automatic t_wait_alt();
		@(posedge mclk);
		stall <= 1'b1;
		alt_pin_a <= 8'h0F;
		alt_pin_b <= 8'hF0;
		tick(2);
		chk("wait", 32'h0, {31'h0, bus_wait_req});
		tick(1);
		chk("wait", 32'h1, {31'h0, bus_wait_req});
		rdr(embpc_pkg::OFS_STATUS);
		chk("status_wait", 32'h2, rd);
		stall <= 1'b0;
		wr(embpc_pkg::OFS_ALT_SEL, 32'h0);
		tick(3);
		chk("alt_a", 32'h0F, {24'h0, alt_in});
		wr(embpc_pkg::OFS_ALT_SEL, 32'hFF);
		tick(3);
		chk("alt_b", 32'hF0, {24'h0, alt_in});
		// Unmapped offset must read as zero
		rdr(8'h14);
		chk("unmapped", 32'h0, rd);
		$display("test wait and alt done");
	endtask : t_wait_alt
	task automatic t_rereset();
		wr(embpc_pkg::OFS_MODE, 32'hF);
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		#1;
		chk("width", 32'h0, {31'h0, bus_width_32});
		chk("p14_oe", 32'h0, {29'h0, p14_pin_oe});
		rdr(embpc_pkg::OFS_MODE);
		chk("mode", 32'h0, rd);
		// Write then read with no gap between the strobes
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= embpc_pkg::OFS_MODE;
		reg_wdata <= 32'h8;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk("mode_b2b", 32'h8, reg_rdata);
		$display("test reset again done");
	endtask : t_rereset
	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		{rstn, reg_wr, reg_rd, stall, reg_addr, reg_wdata, alt_pin_a, alt_pin_b} = '0;
		{port_up_out, port_up_oe, ctrl} = '0;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		t_reset();
		t_width();
		t_p14();
		t_dedicated();
		t_read();
		t_wait_alt();
		t_rereset();
		conclude();
	end
endmodule : test_embpc_top
